/* src/lwc_cmd_engine.sv */
// Purpose: taskfile, log-write and long-write execution over Wishbone
// Assumes: Wishbone master on clk; media side takes one item per cycle
// Notes: taskfile writes are ignored while a command runs
// How it works
// RQ1: log write stores counted 512-byte sectors
// RQ2: interrupt event after every sector block
// RQ3: count is previous and current count bytes
// RQ4: abort when count exceeds directory size
// RQ5: data placed from the log's own sectors
// RQ6: log address from sector number; read-only aborts
// RQ7: start sector is previous and current cylinder low
// RQ8: abort on unsupported log or invalid values
// RQ9: long write passes data and ECC unchanged
// RQ10: DRQ stays set for trailing ECC bytes
// RQ11: data as words, ECC as single bytes
// RQ12: ECC length is 4 or 40 by option; code also offers 52
// RQ13: ECC length defaults to 4 after reset
// RQ14: host sets count to one for long write
// RQ15: LBA bit selects geometric or LBA address
// RQ16: retry bit of long write is ignored
// RQ17: sector count reports sectors not transferred
// RQ18: media ECC is native 52 bytes, padded
// RQ19: abort sets ERR, ABT and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "lwc_consts.svh"
module lwc_cmd_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic media_valid,
  output logic [15:0] media_data,
  output logic media_is_ecc,
  output logic media_is_pad,
  output logic [27:0] media_addr,
  output logic media_lba_mode,
  input wire logic [11:0] log_rd_addr,
  output logic [15:0] log_rd_data
);
  import lwc_pkg::*;

  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [7:0] feat_reg, feat_next, cnt_cur_reg, cnt_cur_next, cnt_prev_reg, cnt_prev_next;
  logic [7:0] snum_cur_reg, snum_cur_next, snum_prev_reg, snum_prev_next;
  logic [7:0] clo_cur_reg, clo_cur_next, clo_prev_reg, clo_prev_next;
  logic [7:0] chi_reg, chi_next, dh_reg, dh_next;
  logic [2:0] cfg_reg, cfg_next, istat_reg, istat_next, imask_reg, imask_next, ev;
  logic err_reg, err_next, abt_reg, abt_next, irq_reg, irq_next, is_log_reg, is_log_next;
  lwc_state_t state_reg, state_next;
  logic [7:0] word_reg, word_next, status_byte;
  logic [5:0] ecc_reg, ecc_next, ecc_last;
  logic [15:0] rem_reg, rem_next, req_cnt, start_sect, dir_size;
  logic [16:0] end_sect;
  logic [1:0] sect_reg, sect_next, lidx_reg, lidx_next, dir_idx;
  logic mvalid_reg, mvalid_next, mbyte_reg, mbyte_next, mpad_reg, mpad_next;
  logic mlba_reg, mlba_next;
  logic [15:0] mdata_reg, mdata_next;
  logic [27:0] maddr_reg, maddr_next;
  logic bus_req, wr_go, dwr, cmd_wr, idle, busy, drq, dir_sup, dir_ro, mem_we;
  logic [11:0] mem_wa;

  // Bus qualifiers; writes land at the edge that sees ack high
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_go = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  assign dwr = wr_go && (wb_adr_i == `LWC_A_DATA);
  assign cmd_wr = wr_go && (wb_adr_i == `LWC_A_CMD_STAT);
  assign idle = (state_reg == LWC_IDLE);
  assign drq = (state_reg == LWC_LOG) || (state_reg == LWC_LDATA) || (state_reg == LWC_LECC);
  assign busy = !idle && !drq;
  assign req_cnt = {cnt_prev_reg, cnt_cur_reg}; // [RQ3]
  assign start_sect = {clo_prev_reg, clo_cur_reg}; // [RQ7]
  assign end_sect = {1'b0, start_sect} + {1'b0, req_cnt};
  assign ecc_last = lwc_ecc_len(cfg_reg[1:0]) - 1'b1; // [RQ12]
  assign mem_we = dwr && (state_reg == LWC_LOG); // [RQ1]
  assign mem_wa = {lidx_reg, sect_reg, word_reg}; // [RQ5]

  // Directory answer follows the sector number register
  lwc_log_dir u_dir (
    .clk(clk),
    .rst(rst),
    .log_addr(snum_cur_reg), // [RQ6]
    .feat_en(cfg_reg[`LWC_CFG_LOGEN]),
    .supported(dir_sup),
    .read_only(dir_ro),
    .size(dir_size),
    .index(dir_idx)
  );

  lwc_log_mem u_mem (
    .clk(clk),
    .rst(rst),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(wb_dat_i[15:0]),
    .raddr(log_rd_addr),
    .rdata(log_rd_data)
  );

  // Status byte and read mux; unmapped offsets read zero
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`LWC_ST_BSY] = busy;
    status_byte[`LWC_ST_RDY] = 1'b1;
    status_byte[`LWC_ST_DSC] = 1'b1;
    status_byte[`LWC_ST_DRQ] = drq;
    status_byte[`LWC_ST_ERR] = err_reg;
    ack_next = bus_req & ~ack_reg;
    rdat_next = rdat_reg;
    if (bus_req && !ack_reg)
    begin
      case (wb_adr_i)
        `LWC_A_FEAT: rdat_next = {24'h00_0000, feat_reg};
        `LWC_A_CNT_CUR: rdat_next = {24'h00_0000, cnt_cur_reg};
        `LWC_A_CNT_PREV: rdat_next = {24'h00_0000, cnt_prev_reg};
        `LWC_A_SNUM_CUR: rdat_next = {24'h00_0000, snum_cur_reg};
        `LWC_A_SNUM_PREV: rdat_next = {24'h00_0000, snum_prev_reg};
        `LWC_A_CLO_CUR: rdat_next = {24'h00_0000, clo_cur_reg};
        `LWC_A_CLO_PREV: rdat_next = {24'h00_0000, clo_prev_reg};
        `LWC_A_CHI: rdat_next = {24'h00_0000, chi_reg};
        `LWC_A_DEVHEAD: rdat_next = {24'h00_0000, dh_reg};
        `LWC_A_CMD_STAT: rdat_next = {24'h00_0000, status_byte};
        `LWC_A_ERROR: rdat_next = {29'h0000_0000, abt_reg, 2'h0};
        `LWC_A_CONFIG: rdat_next = {29'h0000_0000, cfg_reg};
        `LWC_A_IRQ_STAT: rdat_next = {29'h0000_0000, istat_reg};
        `LWC_A_IRQ_MASK: rdat_next = {29'h0000_0000, imask_reg};
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // Taskfile, command sequencer, media stream and interrupt state
  always_comb
  begin
    feat_next = feat_reg;
    cnt_cur_next = cnt_cur_reg;
    cnt_prev_next = cnt_prev_reg;
    snum_cur_next = snum_cur_reg;
    snum_prev_next = snum_prev_reg;
    clo_cur_next = clo_cur_reg;
    clo_prev_next = clo_prev_reg;
    chi_next = chi_reg;
    dh_next = dh_reg;
    cfg_next = cfg_reg;
    imask_next = imask_reg;
    err_next = err_reg;
    abt_next = abt_reg;
    is_log_next = is_log_reg;
    state_next = state_reg;
    word_next = word_reg;
    ecc_next = ecc_reg;
    rem_next = rem_reg;
    sect_next = sect_reg;
    lidx_next = lidx_reg;
    maddr_next = maddr_reg;
    mlba_next = mlba_reg;
    mdata_next = mdata_reg;
    mvalid_next = 1'b0;
    mbyte_next = mbyte_reg;
    mpad_next = 1'b0;
    ev = 3'h0;
    // Parameter writes only while idle, so a running command sees stable values
    if (wr_go && idle)
    begin
      case (wb_adr_i)
        `LWC_A_FEAT: feat_next = wb_dat_i[7:0];
        `LWC_A_CNT_CUR: cnt_cur_next = wb_dat_i[7:0];
        `LWC_A_CNT_PREV: cnt_prev_next = wb_dat_i[7:0];
        `LWC_A_SNUM_CUR: snum_cur_next = wb_dat_i[7:0];
        `LWC_A_SNUM_PREV: snum_prev_next = wb_dat_i[7:0];
        `LWC_A_CLO_CUR: clo_cur_next = wb_dat_i[7:0];
        `LWC_A_CLO_PREV: clo_prev_next = wb_dat_i[7:0];
        `LWC_A_CHI: chi_next = wb_dat_i[7:0];
        `LWC_A_DEVHEAD: dh_next = wb_dat_i[7:0];
        `LWC_A_CONFIG: cfg_next = wb_dat_i[2:0]; // [RQ12]
        default: dh_next = dh_reg;
      endcase
    end
    if (wr_go && (wb_adr_i == `LWC_A_IRQ_MASK))
    begin
      imask_next = wb_dat_i[2:0];
    end
    case (state_reg)
      LWC_IDLE:
      begin
        if (cmd_wr)
        begin
          err_next = 1'b0;
          abt_next = 1'b0;
          is_log_next = (wb_dat_i[7:0] == `LWC_OP_LOG);
          // Low bit of the long write code is the retry flag, not decoded
          if (wb_dat_i[7:0] == `LWC_OP_LOG || wb_dat_i[7:1] == `LWC_OP_LONG) // [RQ16]
          begin
            state_next = LWC_CHECK;
          end
          else
          begin
            state_next = LWC_ABORT;
          end
        end
      end
      LWC_CHECK:
      begin
        word_next = 8'h00;
        if (is_log_reg)
        begin
          if (!dir_sup || dir_ro) // [RQ6] [RQ8]
          begin
            state_next = LWC_ABORT;
          end
          else if (req_cnt > dir_size) // [RQ4]
          begin
            state_next = LWC_ABORT;
          end
          else if (req_cnt == 16'h0000 || end_sect > {1'b0, dir_size}) // [RQ8]
          begin
            state_next = LWC_ABORT;
          end
          else
          begin
            rem_next = req_cnt;
            sect_next = start_sect[1:0]; // [RQ5]
            lidx_next = dir_idx;
            state_next = LWC_LOG;
          end
        end
        else if (cnt_cur_reg != 8'h01) // [RQ14]
        begin
          state_next = LWC_ABORT;
        end
        else
        begin
          // Same packing for both modes; the mode flag tells them apart
          maddr_next = {dh_reg[3:0], chi_reg, clo_cur_reg, snum_cur_reg}; // [RQ15]
          mlba_next = dh_reg[`LWC_DH_LBA]; // [RQ15]
          rem_next = {8'h00, cnt_cur_reg};
          state_next = LWC_LDATA;
        end
      end
      LWC_LOG:
      begin
        if (dwr)
        begin
          word_next = word_reg + 1'b1;
          if (word_reg == `LWC_LAST_WORD)
          begin
            ev[`LWC_IRQ_BLK] = 1'b1; // [RQ2]
            rem_next = rem_reg - 1'b1;
            sect_next = sect_reg + 1'b1;
            if (rem_reg == 16'h0001)
            begin
              state_next = LWC_DONE;
            end
          end
        end
      end
      LWC_LDATA:
      begin
        if (dwr)
        begin
          mvalid_next = 1'b1;
          mdata_next = wb_dat_i[15:0]; // [RQ9] [RQ11]
          mbyte_next = 1'b0;
          word_next = word_reg + 1'b1;
          if (word_reg == `LWC_LAST_WORD)
          begin
            ecc_next = 6'h00;
            state_next = LWC_LECC; // [RQ10]
          end
        end
      end
      LWC_LECC:
      begin
        if (dwr)
        begin
          mvalid_next = 1'b1;
          mdata_next = {8'h00, wb_dat_i[7:0]}; // [RQ11]
          mbyte_next = 1'b1;
          ecc_next = ecc_reg + 1'b1;
          if (ecc_reg == ecc_last)
          begin
            rem_next = 16'h0000;
            // Media always holds native ECC; shorter modes get padded
            if (lwc_ecc_len(cfg_reg[1:0]) == `LWC_ECC_NATIVE) // [RQ18]
            begin
              state_next = LWC_DONE;
            end
            else
            begin
              state_next = LWC_PAD;
            end
          end
        end
      end
      LWC_PAD:
      begin
        mvalid_next = 1'b1;
        mdata_next = 16'h0000;
        mbyte_next = 1'b1;
        mpad_next = 1'b1; // [RQ18]
        ecc_next = ecc_reg + 1'b1;
        if (ecc_reg == `LWC_ECC_NATIVE - 1'b1)
        begin
          state_next = LWC_DONE;
        end
      end
      LWC_DONE:
      begin
        cnt_cur_next = rem_reg[7:0]; // [RQ17]
        cnt_prev_next = rem_reg[15:8];
        ev[`LWC_IRQ_DONE] = 1'b1;
        state_next = LWC_IDLE;
      end
      LWC_ABORT:
      begin
        err_next = 1'b1; // [RQ19]
        abt_next = 1'b1;
        ev[`LWC_IRQ_ABT] = 1'b1;
        state_next = LWC_IDLE;
      end
      default:
      begin
        state_next = LWC_IDLE;
      end
    endcase
    // Set wins over a write-one clear in the same cycle
    istat_next = istat_reg | ev;
    if (wr_go && (wb_adr_i == `LWC_A_IRQ_STAT))
    begin
      istat_next = (istat_reg & ~wb_dat_i[2:0]) | ev;
    end
    irq_next = |(istat_reg & imask_reg);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      feat_reg <= 8'h00;
      cnt_cur_reg <= 8'h00;
      cnt_prev_reg <= 8'h00;
      snum_cur_reg <= 8'h00;
      snum_prev_reg <= 8'h00;
      clo_cur_reg <= 8'h00;
      clo_prev_reg <= 8'h00;
      chi_reg <= 8'h00;
      dh_reg <= `LWC_DH_RST;
      cfg_reg <= `LWC_CFG_RST; // [RQ13]
      imask_reg <= 3'h0;
      istat_reg <= 3'h0;
      irq_reg <= 1'b0;
      err_reg <= 1'b0;
      abt_reg <= 1'b0;
      is_log_reg <= 1'b0;
      state_reg <= LWC_IDLE;
      word_reg <= 8'h00;
      ecc_reg <= 6'h00;
      rem_reg <= 16'h0000;
      sect_reg <= 2'h0;
      lidx_reg <= 2'h0;
      maddr_reg <= 28'h000_0000;
      mlba_reg <= 1'b0;
      mdata_reg <= 16'h0000;
      mvalid_reg <= 1'b0;
      mbyte_reg <= 1'b0;
      mpad_reg <= 1'b0;
    end
    else
    begin
      feat_reg <= feat_next;
      cnt_cur_reg <= cnt_cur_next;
      cnt_prev_reg <= cnt_prev_next;
      snum_cur_reg <= snum_cur_next;
      snum_prev_reg <= snum_prev_next;
      clo_cur_reg <= clo_cur_next;
      clo_prev_reg <= clo_prev_next;
      chi_reg <= chi_next;
      dh_reg <= dh_next;
      cfg_reg <= cfg_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
      irq_reg <= irq_next;
      err_reg <= err_next;
      abt_reg <= abt_next;
      is_log_reg <= is_log_next;
      state_reg <= state_next;
      word_reg <= word_next;
      ecc_reg <= ecc_next;
      rem_reg <= rem_next;
      sect_reg <= sect_next;
      lidx_reg <= lidx_next;
      maddr_reg <= maddr_next;
      mlba_reg <= mlba_next;
      mdata_reg <= mdata_next;
      mvalid_reg <= mvalid_next;
      mbyte_reg <= mbyte_next;
      mpad_reg <= mpad_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign irq_o = irq_reg;
  assign media_valid = mvalid_reg;
  assign media_data = mdata_reg;
  assign media_is_ecc = mbyte_reg;
  assign media_is_pad = mpad_reg;
  assign media_addr = maddr_reg;
  assign media_lba_mode = mlba_reg;

  // Checks on the sequencer
  a_abort_flags: assert property (@(posedge clk) disable iff (rst) // [RQ19]
    state_reg == LWC_ABORT |=> err_reg && abt_reg && istat_reg[`LWC_IRQ_ABT])
    else $error("abort did not set error flags");
  a_ro_log_abort: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    state_reg == LWC_CHECK && is_log_reg && dir_ro |=> state_reg == LWC_ABORT)
    else $error("read only log not aborted");
  a_count_size_abort: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    state_reg == LWC_CHECK && is_log_reg && req_cnt > dir_size |=> state_reg == LWC_ABORT)
    else $error("oversized log count not aborted");
  a_block_irq_set: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    state_reg == LWC_LOG && dwr && word_reg == `LWC_LAST_WORD |=> istat_reg[`LWC_IRQ_BLK])
    else $error("block event missing");
  a_ecc_keeps_drq: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    state_reg == LWC_LDATA && dwr && word_reg == `LWC_LAST_WORD |=> drq && !busy)
    else $error("drq dropped before ecc bytes");
  a_word_passthru: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    state_reg == LWC_LDATA && dwr |=> media_valid && !media_is_ecc
      && media_data == $past(wb_dat_i[15:0]))
    else $error("sector word not passed unchanged");
  a_ecc_byte_lane: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    state_reg == LWC_LECC && dwr |=> media_valid && media_is_ecc
      && media_data[15:8] == 8'h00 && media_data[7:0] == $past(wb_dat_i[7:0]))
    else $error("ecc byte not moved as a byte");
  a_ecc_reset_short: assert property (@(posedge clk) disable iff (rst) // [RQ13]
    $past(rst) |-> lwc_ecc_len(cfg_reg[1:0]) == `LWC_ECC_SHORT)
    else $error("ecc length not short after reset");
  a_long_count_zero: assert property (@(posedge clk) disable iff (rst) // [RQ17]
    state_reg == LWC_DONE && !is_log_reg |=> cnt_cur_reg == 8'h00 && state_reg == LWC_IDLE)
    else $error("long write count not reported");
  a_ack_single: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

/* src/lwc_consts.svh */
// Purpose: named constants of the log-write and long-write command block
// Assumes: included by bare name; guard prevents double definition
// Notes: offsets are byte addresses of 32-bit aligned words
`ifndef LWC_CONSTS_SVH
`define LWC_CONSTS_SVH
// Register byte offsets
`define LWC_A_DATA 8'h00
`define LWC_A_FEAT 8'h04
`define LWC_A_CNT_CUR 8'h08
`define LWC_A_CNT_PREV 8'h0C
`define LWC_A_SNUM_CUR 8'h10
`define LWC_A_SNUM_PREV 8'h14
`define LWC_A_CLO_CUR 8'h18
`define LWC_A_CLO_PREV 8'h1C
`define LWC_A_CHI 8'h20
`define LWC_A_DEVHEAD 8'h24
`define LWC_A_CMD_STAT 8'h28
`define LWC_A_ERROR 8'h2C
`define LWC_A_CONFIG 8'h30
`define LWC_A_IRQ_STAT 8'h34
`define LWC_A_IRQ_MASK 8'h38
// Command codes; long write is matched without its low bit
`define LWC_OP_LOG 8'h3F
`define LWC_OP_LONG 7'h19
// Status, error and device/head bit positions
`define LWC_ST_BSY 7
`define LWC_ST_RDY 6
`define LWC_ST_DSC 4
`define LWC_ST_DRQ 3
`define LWC_ST_ERR 0
`define LWC_ER_ABT 2
`define LWC_DH_LBA 6
// Reset values
`define LWC_DH_RST 8'hA0
`define LWC_CFG_RST 3'h0
// Transfer sizes
`define LWC_LAST_WORD 8'hFF
`define LWC_ECC_SHORT 6'h04
`define LWC_ECC_MID 6'h28
`define LWC_ECC_NATIVE 6'h34
`define LWC_ECC_M_MID 2'h1
`define LWC_ECC_M_NATIVE 2'h2
// Config and interrupt bit positions
`define LWC_CFG_LOGEN 2
`define LWC_IRQ_BLK 0
`define LWC_IRQ_DONE 1
`define LWC_IRQ_ABT 2
// Log directory layout
`define LWC_LOG_DIR 8'h00
`define LWC_LOG_HOST 6'h20
`define LWC_LOG_DEVVS 3'h5
`define LWC_LOG_SECTS 16'h0004
`endif

/* src/lwc_log_dir.sv */
// Purpose: log directory lookup for a log address
// Assumes: address stable one cycle before the answer is used
// Notes: results are registered, one cycle behind the address
`timescale 1ns/10ps
`default_nettype none
module lwc_log_dir (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] log_addr,
  input wire logic feat_en,
  output logic supported,
  output logic read_only,
  output logic [15:0] size,
  output logic [1:0] index
);
  logic sup_reg, sup_next, ro_reg, ro_next;
  logic [15:0] size_reg, size_next;
  logic [1:0] idx_reg, idx_next;

  // Directory and vendor logs are read only; host logs need the feature
  always_comb
  begin
    sup_next = 1'b0;
    ro_next = 1'b0;
    size_next = 16'h0000;
    idx_next = log_addr[1:0];
    if (log_addr == `LWC_LOG_DIR || log_addr[7:5] == `LWC_LOG_DEVVS)
    begin
      sup_next = 1'b1;
      ro_next = 1'b1;
    end
    else if (log_addr[7:2] == `LWC_LOG_HOST)
    begin
      sup_next = feat_en;
      size_next = `LWC_LOG_SECTS;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sup_reg <= 1'b0;
      ro_reg <= 1'b0;
      size_reg <= 16'h0000;
      idx_reg <= 2'h0;
    end
    else
    begin
      sup_reg <= sup_next;
      ro_reg <= ro_next;
      size_reg <= size_next;
      idx_reg <= idx_next;
    end
  end

  assign supported = sup_reg;
  assign read_only = ro_reg;
  assign size = size_reg;
  assign index = idx_reg;
endmodule
`default_nettype wire

/* src/lwc_log_mem.sv */
// Purpose: storage for the host-writable log sectors
// Assumes: one write and one read per cycle
// Notes: read data lands in a register one cycle after the address
`timescale 1ns/10ps
`default_nettype none
module lwc_log_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [11:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [11:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:4095];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Read path; contents are not cleared by reset
  always_comb
  begin
    rdata_next = mem[raddr];
  end

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (rst)
    begin
      rdata_reg <= 16'h0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
endmodule
`default_nettype wire

/* src/lwc_pkg.sv */
// Purpose: types and shared decoding of the command block
// Assumes: constants header on the include path
// Notes: state codes form a Gray sequence in declaration order
package lwc_pkg;
`include "lwc_consts.svh"
  typedef enum logic [2:0] {
    LWC_IDLE = 3'b000,
    LWC_CHECK = 3'b001,
    LWC_LOG = 3'b011,
    LWC_LDATA = 3'b010,
    LWC_LECC = 3'b110,
    LWC_PAD = 3'b111,
    LWC_DONE = 3'b101,
    LWC_ABORT = 3'b100
  } lwc_state_t;

  // ECC bytes the host sends for a given mode
  function automatic logic [5:0] lwc_ecc_len(input logic [1:0] mode);
    case (mode)
      `LWC_ECC_M_MID: lwc_ecc_len = `LWC_ECC_MID;
      `LWC_ECC_M_NATIVE: lwc_ecc_len = `LWC_ECC_NATIVE;
      default: lwc_ecc_len = `LWC_ECC_SHORT;
    endcase
  endfunction
endpackage

/* verif/lwc_cmd_engine_tb_top.sv */
// Purpose: bench for the log-write and long-write engine
// Assumes: host model drives the bus
// Notes: media stream and log port are checked directly
`timescale 1ns/10ps
`default_nettype none
`include "lwc_consts.svh"
module lwc_cmd_engine_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc, stb, we, ack, irq, mv, me, mp, ml;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd, q;
  logic [15:0] md, lrd;
  logic [27:0] ma;
  logic [11:0] lra = 12'h000;
  int err_count = 0;
  int checked = 0;
  int nd, ne, np;
  int lens [3] = '{4, 40, 52};
  lwc_host_model u_lwc_host_model (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(wd), .ack(ack), .din(rd));
  lwc_cmd_engine u_lwc_cmd_engine (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .irq_o(irq), .media_valid(mv), .media_data(md), .media_is_ecc(me),
    .media_is_pad(mp), .media_addr(ma), .media_lba_mode(ml), .log_rd_addr(lra),
    .log_rd_data(lrd));
  // 20 MHz clock
  initial forever #25 clk = ~clk;
  task close_out;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Automatic, since the media watcher and the main thread both call it
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_lwc_host_model.acc(1'b1, a, d, q);
  endtask
  task rr(input logic [7:0] a);
    u_lwc_host_model.acc(1'b0, a, 32'h0000_0000, q);
  endtask
  // Status poll, bounded; leaves status in q
  task poll;
    rr(`LWC_A_CMD_STAT);
    for (int i = 0; i < 20 && q[`LWC_ST_BSY] !== 1'b0; i++) rr(`LWC_A_CMD_STAT);
  endtask
  task cmd(input logic [7:0] op);
    wr(`LWC_A_CMD_STAT, op);
    poll();
  endtask
  // Refused command: error bits, sticky bit, level interrupt
  task abt(input logic [7:0] cf, sn, cn, cl, op);
    wr(`LWC_A_CONFIG, cf);
    wr(`LWC_A_SNUM_CUR, sn);
    wr(`LWC_A_CNT_CUR, cn);
    wr(`LWC_A_CLO_CUR, cl);
    cmd(op);
    chk("abt_err", q[`LWC_ST_ERR], 1'b1);
    rr(`LWC_A_ERROR);
    chk("abt_abt", q[`LWC_ER_ABT], 1'b1);
    rr(`LWC_A_IRQ_STAT);
    chk("abt_ev", q[`LWC_IRQ_ABT], 1'b1);
    chk("irq_on", irq, 1'b1);
    wr(`LWC_A_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("irq_off", irq, 1'b0);
  endtask
  // Media stream watcher: data words, ECC bytes, pad bytes
  always @(posedge clk)
    if (mv === 1'b1)
    begin
      if (mp === 1'b1) chk("pad", md, 0);
      else if (me === 1'b1) chk("ecc", md, 8'hA0 + ne);
      else chk("word", md, 16'(nd));
      if (mp === 1'b1) np++;
      else if (me === 1'b1) ne++;
      else nd++;
    end
  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rr(`LWC_A_CMD_STAT);
    chk("st_rst", q, 32'h0000_0050);
    rr(`LWC_A_DEVHEAD);
    chk("dh_rst", q, `LWC_DH_RST);
    rr(`LWC_A_CONFIG);
    chk("cfg_rst", q[2:0], `LWC_CFG_RST);
    wr(`LWC_A_IRQ_MASK, 32'h0000_0004);
    wr(`LWC_A_CNT_PREV, 8'h00);
    wr(`LWC_A_CLO_PREV, 8'h00);
    abt(8'h04, 8'h00, 8'h01, 8'h00, `LWC_OP_LOG);
    abt(8'h00, 8'h80, 8'h01, 8'h00, `LWC_OP_LOG);
    abt(8'h04, 8'h80, 8'h05, 8'h00, `LWC_OP_LOG);
    abt(8'h04, 8'h80, 8'h02, 8'h03, `LWC_OP_LOG);
    abt(8'h00, 8'h11, 8'h02, 8'h00, 8'h32);
    abt(8'h00, 8'h11, 8'h01, 8'h00, 8'h55);
    // Log write: two sectors into log 0x81 from its sector 1
    wr(`LWC_A_IRQ_MASK, 32'h0000_0000);
    wr(`LWC_A_CONFIG, 8'h04);
    wr(`LWC_A_SNUM_CUR, 8'h81);
    wr(`LWC_A_CNT_CUR, 8'h02);
    wr(`LWC_A_CLO_CUR, 8'h01);
    cmd(`LWC_OP_LOG);
    chk("log_drq", q[`LWC_ST_DRQ], 1'b1);
    for (int n = 0; n < 2; n++)
    begin
      for (int w = 0; w < 256; w++) wr(`LWC_A_DATA, n * 256 + w);
      poll();
      rr(`LWC_A_IRQ_STAT);
      chk("log_ev", q[2:0], n ? 3'h3 : 3'h1);
      chk("irq_mask", irq, 1'b0);
      wr(`LWC_A_IRQ_STAT, 32'h0000_0007);
    end
    rr(`LWC_A_CNT_CUR);
    chk("log_left", q[7:0], 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      lra <= {2'd1, 2'(k / 2 + 1), 8'(k % 2 * 255)};
      repeat (2) @(posedge clk);
      chk("log_mem", lrd, k / 2 * 256 + k % 2 * 255);
    end
    // Long write, each ECC length; geometric mode and clear retry bit in the middle pass
    wr(`LWC_A_SNUM_CUR, 8'h11);
    wr(`LWC_A_CLO_CUR, 8'h22);
    wr(`LWC_A_CHI, 8'h33);
    for (int m = 0; m < 3; m++)
    begin
      wr(`LWC_A_CONFIG, m);
      wr(`LWC_A_DEVHEAD, m == 1 ? 8'hA3 : 8'hE3);
      wr(`LWC_A_CNT_CUR, 8'h01);
      nd = 0;
      ne = 0;
      np = 0;
      cmd(m == 1 ? 8'h32 : 8'h33);
      for (int w = 0; w < 256; w++) wr(`LWC_A_DATA, 32'hFFFF_0000 | w);
      rr(`LWC_A_CMD_STAT);
      chk("ecc_drq", q[`LWC_ST_DRQ], 1'b1);
      for (int e = 0; e < lens[m]; e++) wr(`LWC_A_DATA, 32'h0000_FF00 | (8'hA0 + e));
      poll();
      chk("n_word", nd, 256);
      chk("n_ecc", ne, lens[m]);
      chk("n_pad", np, 52 - lens[m]);
      chk("m_addr", ma, 28'h333_2211);
      chk("m_lba", ml, m != 1);
      rr(`LWC_A_CNT_CUR);
      chk("long_left", q[7:0], 8'h00);
    end
    close_out();
  end
endmodule
`default_nettype wire

/* verif/lwc_host_model.sv */
// Purpose: host side model, Wishbone classic master
// Assumes: slave acks a held request
// Notes: no local limit on the ack wait; the bench watchdog ends a hang
`timescale 1ns/10ps
`default_nettype none
module lwc_host_model (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic ack,
  input wire logic [31:0] din
);
  // Idle bus from time zero
  initial
  begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end
  // Request held until an edge sees ack; released only then
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = din;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule
`default_nettype wire
